//--- src/lfs_link_status_regs.sv
// Module: link frame-marker select, link status flags and their Wishbone register bank
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
module lfs_link_status_regs #(
    parameter int ADR_W = 12,
    parameter int DAT_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone classic slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [ADR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [DAT_W-1:0] wbDatIn,
    output logic [DAT_W-1:0] wbDatOut,
    output logic wbAck,
    // Link state from the transmit core
    input wire logic linkUp,
    input wire logic syncN,
    input wire logic pllLocked,
    input wire logic sysrefEvent,
    input wire logic sysrefPhaseShift,
    // Frame octet stream in
    input wire logic [7:0] frameOctet,
    input wire logic frameOctetIsK,
    input wire logic frameLastOctet,
    input wire logic frameReplaceOk,
    // Encoder-facing symbol out
    output logic [7:0] txSymbol,
    output logic txSymbolIsK,
    // Configuration towards the link core
    output logic linkBlockEnable,
    output logic linkMode64b66b,
    output logic [1:0] channelPowerDown
);
    // ********************************************************
    // Elaboration checks
    // ********************************************************
    // Refused at elaboration: the map and read mux assume a 32-bit word and an address of at least 12 bits
    if (DAT_W != 32) begin : gBadDatW
        $error("DAT_W must be 32");
    end
    if (ADR_W < 12) begin : gBadAdrW
        $error("ADR_W must be at least 12");
    end

    // ********************************************************
    // Storage
    // ********************************************************
    logic [1:0] eofSelect;
    logic realigned;
    logic phaseSet;
    logic phaseArmed;
    logic enablePrev;
    logic linkUpQ;
    logic syncQ;
    logic pllQ;

    // ********************************************************
    // Bus decode
    // ********************************************************
    wire [9:0] regIdx = wbAdr[11:2];
    wire busReq = wbCyc & wbStb;
    wire startRead = busReq & ~wbAck & ~wbWe;
    // Writes land on the edge where the master sees ack
    wire lowLane = busReq & wbAck & wbWe & wbSel[0];
    wire hitEof = (regIdx == lfs_pkg::IDX_EOF_SEL);
    wire hitStatus = (regIdx == lfs_pkg::IDX_STATUS);
    wire hitPd = (regIdx == lfs_pkg::IDX_PWR_DOWN);
    wire hitCtl = (regIdx == lfs_pkg::IDX_CONTROL);
    wire wrEof = lowLane & hitEof;
    wire wrStatus = lowLane & hitStatus;
    wire wrPd = lowLane & hitPd;
    wire wrCtl = lowLane & hitCtl;

    // ********************************************************
    // Status flag next values
    // ********************************************************
    // Set beats a same-cycle write-1 clear so no event is lost
    wire clrRealigned = wrStatus & wbDatIn[lfs_pkg::ST_REALIGNED];
    wire clrPhaseSet = wrStatus & wbDatIn[lfs_pkg::ST_PHASE_SET];
    wire setRealigned = sysrefEvent & sysrefPhaseShift;
    wire enableRise = linkBlockEnable & ~enablePrev;
    wire setPhaseSet = sysrefEvent & phaseArmed;
    wire next_realigned = (realigned & ~clrRealigned) | setRealigned;
    wire next_phaseSet = (phaseSet & ~clrPhaseSet) | setPhaseSet;
    // Armed from enable rise until the first SYSREF consumes it
    wire next_phaseArmed = (phaseArmed & ~sysrefEvent) | enableRise;

    // ********************************************************
    // Read data mux
    // ********************************************************
    wire [7:0] statusByte = {1'b0, linkUpQ, syncQ, realigned,
                             phaseSet, pllQ, 2'b00};
    wire [7:0] eofByte = {6'h00, eofSelect};
    wire [7:0] pdByte = {6'h00, channelPowerDown};
    wire [7:0] ctlByte = {6'h00, linkMode64b66b, linkBlockEnable};
    // Unmapped addresses answer normally with zero data
    wire [7:0] rdByte = hitEof ? eofByte :
                        hitStatus ? statusByte :
                        hitPd ? pdByte :
                        hitCtl ? ctlByte : 8'h00;

    // ********************************************************
    // Marker path
    // ********************************************************
    // Reserved code 3 falls back to the compliant K28.7
    wire [7:0] markerSym = (eofSelect == lfs_pkg::EOF_K28_1) ? lfs_pkg::SYM_K28_1 :
                           (eofSelect == lfs_pkg::EOF_K28_5) ? lfs_pkg::SYM_K28_5 :
                           lfs_pkg::SYM_K28_7;
    wire mode8b10b = ~linkMode64b66b;
    wire putMarker = linkBlockEnable & mode8b10b & frameLastOctet
                     & frameReplaceOk;
    wire [7:0] next_txSymbol = ~linkBlockEnable ? lfs_pkg::SYM_IDLE :
                               putMarker ? markerSym : frameOctet;
    wire next_txSymbolIsK = linkBlockEnable & (putMarker | frameOctetIsK);

    // ********************************************************
    // Bus handshake
    // ********************************************************
    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= busReq & ~wbAck;
        end
    end

    // Read data captured with the ack it travels with
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wbDatOut <= '0;
        end else if (startRead) begin
            wbDatOut <= {{(DAT_W-8){1'b0}}, rdByte};
        end else if (!busReq) begin
            wbDatOut <= '0;
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    // Selection is not guarded by enable; host must keep it stable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eofSelect <= lfs_pkg::RST_EOF_SEL;
        end else if (wrEof) begin
            eofSelect <= wbDatIn[1:0];
        end
    end

    // Channel power-down bits, plain storage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channelPowerDown <= lfs_pkg::RST_PWR_DOWN;
        end else if (wrPd) begin
            channelPowerDown <= wbDatIn[1:0];
        end
    end

    // Link enable and encoding mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linkBlockEnable <= lfs_pkg::RST_ENABLE;
            linkMode64b66b <= lfs_pkg::RST_MODE64;
        end else if (wrCtl) begin
            linkBlockEnable <= wbDatIn[lfs_pkg::CTL_ENABLE];
            linkMode64b66b <= wbDatIn[lfs_pkg::CTL_MODE64];
        end
    end

    // ********************************************************
    // Status capture
    // ********************************************************
    // Live levels sampled once so a read sees one coherent cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linkUpQ <= 1'b0;
            syncQ <= 1'b0;
            pllQ <= 1'b0;
        end else begin
            linkUpQ <= linkUp;
            syncQ <= syncN;
            pllQ <= pllLocked;
        end
    end

    // Sticky alignment flags and the arming latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            realigned <= 1'b0;
            phaseSet <= 1'b0;
            phaseArmed <= 1'b0;
            enablePrev <= 1'b0;
        end else begin
            realigned <= next_realigned;
            phaseSet <= next_phaseSet;
            phaseArmed <= next_phaseArmed;
            enablePrev <= linkBlockEnable;
        end
    end

    // ********************************************************
    // Symbol output
    // ********************************************************
    // One register stage; marker substitution costs no extra latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txSymbol <= lfs_pkg::SYM_IDLE;
            txSymbolIsK <= 1'b0;
        end else begin
            txSymbol <= next_txSymbol;
            txSymbolIsK <= next_txSymbolIsK;
        end
    end
endmodule

//--- src/lfs_pkg.sv
// Package: register map, field layout and symbol codes of the link frame/status bank
package lfs_pkg;
    // ********************************************************
    // Register indices (byte address is four times the index)
    // ********************************************************
    localparam logic [9:0] IDX_EOF_SEL = 10'h207;
    localparam logic [9:0] IDX_STATUS = 10'h208;
    localparam logic [9:0] IDX_PWR_DOWN = 10'h209;
    localparam logic [9:0] IDX_CONTROL = 10'h280;

    // ********************************************************
    // Field positions and widths
    // ********************************************************
    localparam int EOF_W = 2;
    localparam int PD_W = 2;
    localparam int ST_LINK_UP = 6;
    localparam int ST_SYNC = 5;
    localparam int ST_REALIGNED = 4;
    localparam int ST_PHASE_SET = 3;
    localparam int ST_PLL_LOCK = 2;
    localparam int CTL_ENABLE = 0;
    localparam int CTL_MODE64 = 1;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [1:0] RST_EOF_SEL = 2'h0;
    localparam logic [1:0] RST_PWR_DOWN = 2'h0;
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_MODE64 = 1'b0;

    // ********************************************************
    // End-of-frame select codes and control symbols
    // ********************************************************
    localparam logic [1:0] EOF_K28_7 = 2'h0;
    localparam logic [1:0] EOF_K28_1 = 2'h1;
    localparam logic [1:0] EOF_K28_5 = 2'h2;
    localparam logic [7:0] SYM_K28_7 = 8'hfc;
    localparam logic [7:0] SYM_K28_1 = 8'h3c;
    localparam logic [7:0] SYM_K28_5 = 8'hbc;
    localparam logic [7:0] SYM_IDLE = 8'h00;
endpackage

//--- tb/lfs_status_properties.sv
// Checker: bus handshake, status bits and end-of-frame symbol path
`timescale 1ns/1ns
module lfs_status_props (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register bus
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [11:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    input wire logic [31:0] wbDatOut,
    input wire logic wbAck,
    // Link state
    input wire logic linkUp,
    input wire logic syncN,
    input wire logic pllLocked,
    input wire logic sysrefEvent,
    input wire logic sysrefPhaseShift,
    // Symbol path
    input wire logic [7:0] frameOctet,
    input wire logic frameOctetIsK,
    input wire logic frameLastOctet,
    input wire logic frameReplaceOk,
    input wire logic [7:0] txSymbol,
    input wire logic txSymbolIsK,
    input wire logic linkBlockEnable,
    input wire logic linkMode64b66b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [1:0] selCode;
    // Decodes; live checks only trust reads where the input sat still for two samples
    wire rdSt = wbAck && !wbWe && wbAdr[11:2] == lfs_pkg::IDX_STATUS;
    wire setSel = wbAck && wbWe && wbSel[0] && wbAdr[11:2] == lfs_pkg::IDX_EOF_SEL;
    wire [2:0] liveIn = {linkUp, syncN, pllLocked};
    wire subst = linkBlockEnable && !linkMode64b66b && frameLastOctet && frameReplaceOk;
    wire [7:0] mark = selCode == 2'h1 ? lfs_pkg::SYM_K28_1 :
        selCode == 2'h2 ? lfs_pkg::SYM_K28_5 : lfs_pkg::SYM_K28_7;
    // Shadow of the marker select, updated at the write's ack edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            selCode <= 2'h0;
        end else if (setSel) begin
            selCode <= wbDatIn[1:0];
        end
    end
    chk_ack_delay: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wbAck |=> !wbAck)
        else $error("ack longer than one cycle");
    chk_link_up: assert property (rdSt && $past(liveIn, 2) == $past(liveIn)
        |-> wbDatOut[6] == $past(linkUp)) else $error("link-up bit wrong");
    chk_sync_level: assert property (rdSt && $past(liveIn, 2) == $past(liveIn)
        |-> wbDatOut[5] == $past(syncN)) else $error("sync bit wrong");
    chk_pll_lock: assert property (rdSt && $past(liveIn, 2) == $past(liveIn)
        |-> wbDatOut[2] == $past(pllLocked)) else $error("pll lock bit wrong");
    chk_marker_sub: assert property (subst |=> txSymbolIsK && txSymbol == $past(mark))
        else $error("marker symbol wrong");
    chk_pass_thru: assert property (linkBlockEnable && !(frameLastOctet && frameReplaceOk)
        |=> txSymbol == $past(frameOctet) && txSymbolIsK == $past(frameOctetIsK))
        else $error("octet replaced without permission");
    chk_no_sub_64: assert property (linkBlockEnable && linkMode64b66b
        |=> txSymbol == $past(frameOctet) && txSymbolIsK == $past(frameOctetIsK))
        else $error("marker inserted in 64b66b mode");
    chk_realign_flag: assert property (rdSt && !$past(wbAck, 2)
        && $past(sysrefEvent && sysrefPhaseShift, 3) |-> wbDatOut[4])
        else $error("realign flag not set");
endmodule
bind lfs_link_status_regs lfs_status_props chk (.clk, .resetn, .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .linkUp, .syncN, .pllLocked, .sysrefEvent,
    .sysrefPhaseShift, .frameOctet, .frameOctetIsK, .frameLastOctet, .frameReplaceOk,
    .txSymbol, .txSymbolIsK, .linkBlockEnable, .linkMode64b66b);

//--- tb/lfs_rx_model.sv
// Far-side 8b/10b receiver model: tallies end-of-frame markers
`timescale 1ns/1ns
module lfs_rx_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Symbol stream
    input wire logic [7:0] txSymbol,
    input wire logic txSymbolIsK,
    // Marker tally
    output int markCount
);
    // All three markers share the K28 low bits, so one compare catches them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            markCount <= 0;
        end else if (txSymbolIsK && txSymbol[4:0] == 5'h1c) begin
            markCount <= markCount + 1;
        end
    end
endmodule

//--- tb/lfs_link_status_regs_test.sv
// Testbench: register bus, status flags and end-of-frame marker path
`timescale 1ns/1ns
module lfs_link_status_regs_test;
    logic clk = 1'h0, resetn = 1'h0, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, wbAck;
    logic [11:0] wbAdr = 12'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0, wbDatOut, rd, d;
    logic linkUp = 1'h0, syncN = 1'h1, pllLocked = 1'h1, sysrefEvent = 1'h0;
    logic sysrefPhaseShift = 1'h0, frameOctetIsK = 1'h0, frameLastOctet = 1'h0;
    logic frameReplaceOk = 1'h0, txSymbolIsK, linkBlockEnable, linkMode64b66b;
    logic [7:0] frameOctet = 8'h0, txSymbol, o;
    logic [1:0] channelPowerDown;
    logic [2:0] live = 3'h3;
    int n_mismatch = 0, tests_run = 0, seed = 32'h61f7, markCount;
    lfs_link_status_regs DUT (.clk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn,
        .wbDatOut, .wbAck, .linkUp, .syncN, .pllLocked, .sysrefEvent, .sysrefPhaseShift,
        .frameOctet, .frameOctetIsK, .frameLastOctet, .frameReplaceOk, .txSymbol,
        .txSymbolIsK, .linkBlockEnable, .linkMode64b66b, .channelPowerDown);
    lfs_rx_model rxModel (.clk, .resetn, .txSymbol, .txSymbolIsK, .markCount);
    always #50 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    // Classic cycle: hold everything until ack, then release for a gap cycle
    task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] v, input logic [3:0] s);
        @(posedge clk);
        {wbCyc, wbStb, wbWe, wbSel} <= {2'h3, we, s};
        wbAdr <= {idx, 2'h0};
        wbDatIn <= v;
        @(posedge clk);
        while (wbAck !== 1'h1) @(posedge clk);
        rd = wbDatOut;
        {wbCyc, wbStb} <= 2'h0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] v);
        wb(1'h1, idx, v, 4'hf);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input string what);
        wb(1'h0, idx, 32'h0, 4'hf);
        chk(rd, exp, what);
    endtask
    // One frame-end octet; pass selects plain forwarding as the expectation
    task automatic sym(input logic ok, input logic pass, input logic [7:0] mk);
        o = 8'($random(seed));
        @(posedge clk);
        {frameOctet, frameLastOctet, frameReplaceOk} <= {o, 1'h1, ok};
        @(posedge clk);
        {frameLastOctet, frameReplaceOk} <= 2'h0;
        @(negedge clk);
        chk({txSymbolIsK, txSymbol}, pass ? {1'h0, o} : {1'h1, mk}, "symbol out");
    endtask
    task automatic pulse(input logic s);
        @(posedge clk);
        {sysrefEvent, sysrefPhaseShift} <= {1'h1, s};
        @(posedge clk);
        {sysrefEvent, sysrefPhaseShift} <= 2'h0;
    endtask
    function automatic logic [31:0] expSt(logic [2:0] l, logic [1:0] f);
        return {25'h0, l[2:1], f, l[0], 2'h0};
    endfunction
    function automatic logic [7:0] markOf(logic [1:0] c);
        return c == 2'h1 ? lfs_pkg::SYM_K28_1 : c == 2'h2 ? lfs_pkg::SYM_K28_5 : lfs_pkg::SYM_K28_7;
    endfunction
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog well beyond the expected run of under two hundred cycles
    initial begin
        #300000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        rdc(lfs_pkg::IDX_EOF_SEL, 32'h0, "select reset");
        repeat (8) begin
            live = 3'($random(seed));
            {linkUp, syncN, pllLocked} <= live;
            repeat (2) @(posedge clk);
            rdc(lfs_pkg::IDX_STATUS, expSt(live, 2'h0), "live status");
        end
        d = $random(seed);
        wr(lfs_pkg::IDX_PWR_DOWN, d);
        wb(1'h1, lfs_pkg::IDX_PWR_DOWN, ~d, 4'he);
        rdc(lfs_pkg::IDX_PWR_DOWN, {30'h0, d[1:0]}, "power-down readback");
        chk({30'h0, channelPowerDown}, {30'h0, d[1:0]}, "power-down output");
        wr(10'h1ff, d);
        rdc(10'h1ff, 32'h0, "unmapped read");
        $display("register and status test done");
        for (int c = 0; c < 4; c++) begin
            wr(lfs_pkg::IDX_CONTROL, 32'h0);
            wr(lfs_pkg::IDX_EOF_SEL, c);
            rdc(lfs_pkg::IDX_EOF_SEL, c, "select readback");
            wr(lfs_pkg::IDX_CONTROL, 32'h1);
            sym(1'h1, 1'h0, markOf(c[1:0]));
            sym(1'h0, 1'h1, 8'h0);
        end
        wr(lfs_pkg::IDX_CONTROL, 32'h3);
        sym(1'h1, 1'h1, 8'h0);
        chk({30'h0, linkMode64b66b, linkBlockEnable}, 32'h3, "control outputs");
        chk(markCount, 32'h4, "receiver marker tally");
        $display("marker test done");
        wr(lfs_pkg::IDX_CONTROL, 32'h0);
        wr(lfs_pkg::IDX_CONTROL, 32'h1);
        pulse(1'h0);
        rdc(lfs_pkg::IDX_STATUS, expSt(live, 2'h1), "phase flag set");
        pulse(1'h1);
        rdc(lfs_pkg::IDX_STATUS, expSt(live, 2'h3), "realign flag set");
        wr(lfs_pkg::IDX_STATUS, 32'h08);
        pulse(1'h0);
        rdc(lfs_pkg::IDX_STATUS, expSt(live, 2'h2), "phase flag cleared");
        wr(lfs_pkg::IDX_STATUS, 32'h10);
        rdc(lfs_pkg::IDX_STATUS, expSt(live, 2'h0), "realign flag cleared");
        $display("flag test done");
        results();
    end
endmodule
